// ---- shared/core_pkg.sv ----
package core_pkg;
    // Instruction word fields
    localparam int FA_MSB = 7;
    localparam int NIB_MSB = 3;
    localparam int D_POS = 8;
    localparam int T_POS = 9;
    localparam int B_LSB = 8;
    localparam int B_MSB = 10;
    localparam int TGT_MSB = 12;
    localparam int TGT_W = 13;
    // Status flag positions and update masks
    localparam int FLG_C = 0;
    localparam int FLG_DC = 1;
    localparam int FLG_Z = 2;
    localparam int FLG_OV = 3;
    localparam logic [3:0] FM_ARITH = 4'hF;
    localparam logic [3:0] FM_Z = 4'h4;
    localparam logic [3:0] FM_C = 4'h1;
    // Byte-oriented opcodes, upper seven bits (d or s below)
    localparam logic [6:0] OPC_SUBB = 7'h01;
    localparam logic [6:0] OPC_SUB = 7'h02;
    localparam logic [6:0] OPC_DEC = 7'h03;
    localparam logic [6:0] OPC_OR = 7'h04;
    localparam logic [6:0] OPC_AND = 7'h05;
    localparam logic [6:0] OPC_XOR = 7'h06;
    localparam logic [6:0] OPC_ADD = 7'h07;
    localparam logic [6:0] OPC_ADDC = 7'h08;
    localparam logic [6:0] OPC_COM = 7'h09;
    localparam logic [6:0] OPC_INC = 7'h0A;
    localparam logic [6:0] OPC_DECSZ = 7'h0B;
    localparam logic [6:0] OPC_RRC = 7'h0C;
    localparam logic [6:0] OPC_RLC = 7'h0D;
    localparam logic [6:0] OPC_SWAP = 7'h0E;
    localparam logic [6:0] OPC_INCSZ = 7'h0F;
    localparam logic [6:0] OPC_RRN = 7'h10;
    localparam logic [6:0] OPC_RLN = 7'h11;
    localparam logic [6:0] OPC_INCSNZ = 7'h12;
    localparam logic [6:0] OPC_DECSNZ = 7'h13;
    localparam logic [6:0] OPC_CLR = 7'h14;
    localparam logic [6:0] OPC_SET = 7'h15;
    localparam logic [6:0] OPC_NEG = 7'h16;
    localparam logic [6:0] OPC_DAW = 7'h17;
    localparam logic [6:0] OPC_BANKHI = 7'h5D;
    // Whole upper byte opcodes
    localparam logic [7:0] OPC_MOVWF = 8'h01;
    localparam logic [7:0] OPC_CPLT = 8'h30;
    localparam logic [7:0] OPC_CPEQ = 8'h31;
    localparam logic [7:0] OPC_CPGT = 8'h32;
    localparam logic [7:0] OPC_TST = 8'h33;
    localparam logic [7:0] OPC_MULF = 8'h34;
    localparam logic [7:0] OPC_MOVL = 8'hB0;
    localparam logic [7:0] OPC_ADDL = 8'hB1;
    localparam logic [7:0] OPC_SUBL = 8'hB2;
    localparam logic [7:0] OPC_ORL = 8'hB3;
    localparam logic [7:0] OPC_XORL = 8'hB4;
    localparam logic [7:0] OPC_ANDL = 8'hB5;
    localparam logic [7:0] OPC_RETL = 8'hB6;
    localparam logic [7:0] OPC_LONG_SUBROUTINE_CALL = 8'hB7;
    localparam logic [7:0] OPC_BANKLO = 8'hB8;
    localparam logic [7:0] OPC_MULL = 8'hBC;
    // Bit, table and branch prefixes, whole-word opcodes and PCL address
    localparam logic [4:0] OPC_BTG = 5'h07;
    localparam logic [4:0] OPC_BSF = 5'h10;
    localparam logic [4:0] OPC_BCF = 5'h11;
    localparam logic [4:0] OPC_BTSS = 5'h12;
    localparam logic [4:0] OPC_BTSC = 5'h13;
    localparam logic [5:0] OPC_TBLRD = 6'h2A;
    localparam logic [5:0] OPC_TBLWT = 6'h2B;
    localparam logic [2:0] OPC_GOTO = 3'h6;
    localparam logic [2:0] OPC_CALL = 3'h7;
    localparam logic [15:0] W_NOP = 16'h0000;
    localparam logic [15:0] W_RET = 16'h0002;
    localparam logic [15:0] W_RETURN_ENABLE_IRQ = 16'h0005;
    localparam logic [7:0] PCL_FILE_ADDR = 8'h02;
    // Register map and reset values
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_CORE = 4'h4;
    localparam logic [3:0] REG_BANK = 4'h8;
    localparam logic [3:0] REG_PC = 4'hC;
    localparam int CTRL_RUN = 0;
    localparam int CTRL_MUL_OFF = 1;
    localparam int CTRL_IRQ_DIS = 2;
    localparam logic [2:0] CTRL_RESET = 3'h1;
    localparam logic [15:0] PC_RESET = 16'h0000;

    typedef enum logic [1:0] {PH_Q1, PH_Q2, PH_Q3, PH_Q4} phase_t;

    typedef enum logic [5:0] {
        OP_NOP, OP_ADD, OP_ADDC, OP_SUB, OP_SUBB, OP_AND, OP_OR, OP_XOR,
        OP_COM, OP_CLR, OP_SET, OP_NEG, OP_DAW, OP_DEC, OP_INC, OP_DECSZ,
        OP_DECSNZ, OP_INCSZ, OP_INCSNZ, OP_CPEQ, OP_CPGT, OP_CPLT, OP_TST,
        OP_RLC, OP_RRC, OP_RLN, OP_RRN, OP_SWAP, OP_MOVWF, OP_MULF, OP_BCF,
        OP_BSF, OP_BTG, OP_BTSC, OP_BTSS, OP_ADDL, OP_SUBL, OP_ANDL, OP_ORL,
        OP_XORL, OP_MOVL, OP_MULL, OP_RETL, OP_CALL, OP_GOTO, OP_LONG_SUBROUTINE_CALL,
        OP_BANKLO, OP_BANKHI, OP_RET, OP_RETURN_ENABLE_IRQ, OP_TBLRD, OP_TBLWT
    } op_t;

    typedef struct packed {
        logic [7:0] res;
        logic [3:0] flg;
        logic [3:0] fmask;
        logic wr_file;
        logic wr_acc;
        logic skip;
    } alu_out_t;
endpackage

// ---- logic/core_decoder.sv ----
// Function
// - Bit clear/set/toggle read, modify one bit, write back
// - Four quarter phases per instruction cycle
// - Q1 decode/NOP, Q2 read, Q3 execute, Q4 write
// - Add, add-carry, sub-borrow update OV C DC Z
// - AND, OR, XOR update zero only
// - Clear/set/neg/DAW select one: file only; zero: file and accumulator
// - Compare-skip unsigned, flags untouched
// - Inc/dec skip write result, no flags
// - Taken skip replaces fetched word with NOP
// - Conditional skip takes two cycles when true
// - Rotate through carry touches carry only
// - Multiply changes no flags; legacy lacks it
// - Bit ops: 3-bit index, 8-bit address, no flags
// - Literal ops: arithmetic all flags, logic zero
// - Branches two cycles, table read to PCL three
// - Long call: latch high, literal low
// - Internal table write until interrupt; external two
// - Bank loads change one nibble only
// - Interrupt return pops and clears disable flag
// - Destination zero accumulator, one file register
`timescale 1ns/1ps
module core_decoder #(
    parameter int STACK_DEPTH = 16,
    parameter bit MUL_PRESENT = 1'b1
) (
    // Clock and reset
    input wire logic sys_clk_in,
    input wire logic reset_in,
    // Program memory
    output logic [15:0] pm_addr_out,
    input wire logic [15:0] pm_data_in,
    // File register port
    output logic [7:0] file_addr_out,
    input wire logic [7:0] file_rdata_in,
    output logic [7:0] file_wdata_out,
    output logic file_we_out,
    // Table access
    input wire logic [15:0] tbl_latch_in,
    input wire logic tbl_internal_in,
    input wire logic irq_event_in,
    output logic [7:0] tbl_wdata_out,
    output logic tbl_we_out,
    output logic tbl_hi_out,
    output logic tbl_inc_out,
    // Core status
    output core_pkg::phase_t phase_out,
    output logic irq_disable_out,
    // Avalon-MM slave
    input wire logic [3:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out
);
    import core_pkg::*;

    localparam int SPW = $clog2(STACK_DEPTH);

    // Refuse stack sizes the wrapping pointer cannot serve
    if (STACK_DEPTH < 2 || (1 << SPW) != STACK_DEPTH) begin : g_bad_depth
        $error("STACK_DEPTH must be a power of two of at least 2");
    end

    // Opcode decode; multiply folds to NOP when absent
    function automatic op_t decode(input logic [15:0] w, input logic mul_ok);
        op_t o;
        o = OP_NOP;
        casez (w[15:8])
            {OPC_SUBB, 1'b?}: o = OP_SUBB;
            {OPC_SUB, 1'b?}: o = OP_SUB;
            {OPC_DEC, 1'b?}: o = OP_DEC;
            {OPC_OR, 1'b?}: o = OP_OR;
            {OPC_AND, 1'b?}: o = OP_AND;
            {OPC_XOR, 1'b?}: o = OP_XOR;
            {OPC_ADD, 1'b?}: o = OP_ADD;
            {OPC_ADDC, 1'b?}: o = OP_ADDC;
            {OPC_COM, 1'b?}: o = OP_COM;
            {OPC_INC, 1'b?}: o = OP_INC;
            {OPC_DECSZ, 1'b?}: o = OP_DECSZ;
            {OPC_RRC, 1'b?}: o = OP_RRC;
            {OPC_RLC, 1'b?}: o = OP_RLC;
            {OPC_SWAP, 1'b?}: o = OP_SWAP;
            {OPC_INCSZ, 1'b?}: o = OP_INCSZ;
            {OPC_RRN, 1'b?}: o = OP_RRN;
            {OPC_RLN, 1'b?}: o = OP_RLN;
            {OPC_INCSNZ, 1'b?}: o = OP_INCSNZ;
            {OPC_DECSNZ, 1'b?}: o = OP_DECSNZ;
            {OPC_CLR, 1'b?}: o = OP_CLR;
            {OPC_SET, 1'b?}: o = OP_SET;
            {OPC_NEG, 1'b?}: o = OP_NEG;
            {OPC_DAW, 1'b?}: o = OP_DAW;
            {OPC_BANKHI, 1'b?}: o = OP_BANKHI;
            OPC_MOVWF: o = OP_MOVWF;
            OPC_CPLT: o = OP_CPLT;
            OPC_CPEQ: o = OP_CPEQ;
            OPC_CPGT: o = OP_CPGT;
            OPC_TST: o = OP_TST;
            OPC_MULF: o = mul_ok ? OP_MULF : OP_NOP;
            OPC_MOVL: o = OP_MOVL;
            OPC_ADDL: o = OP_ADDL;
            OPC_SUBL: o = OP_SUBL;
            OPC_ORL: o = OP_ORL;
            OPC_XORL: o = OP_XORL;
            OPC_ANDL: o = OP_ANDL;
            OPC_RETL: o = OP_RETL;
            OPC_LONG_SUBROUTINE_CALL: o = OP_LONG_SUBROUTINE_CALL;
            OPC_BANKLO: o = OP_BANKLO;
            OPC_MULL: o = mul_ok ? OP_MULL : OP_NOP;
            {OPC_BTG, 3'h?}: o = OP_BTG;
            {OPC_BSF, 3'h?}: o = OP_BSF;
            {OPC_BCF, 3'h?}: o = OP_BCF;
            {OPC_BTSS, 3'h?}: o = OP_BTSS;
            {OPC_BTSC, 3'h?}: o = OP_BTSC;
            {OPC_TBLRD, 2'h?}: o = OP_TBLRD;
            {OPC_TBLWT, 2'h?}: o = OP_TBLWT;
            {OPC_GOTO, 5'h??}: o = OP_GOTO;
            {OPC_CALL, 5'h??}: o = OP_CALL;
            default: o = OP_NOP;
        endcase
        if (w == W_RET) o = OP_RET;
        if (w == W_RETURN_ENABLE_IRQ) o = OP_RETURN_ENABLE_IRQ;
        return o;
    endfunction

    // Execute stage: result, flags, destinations and skip
    function automatic alu_out_t alu(input op_t op, input logic [7:0] a,
        input logic [7:0] f, input logic [7:0] k, input logic [2:0] b,
        input logic d, input logic [3:0] st);
        alu_out_t r;
        logic [7:0] x;
        logic [7:0] y;
        logic [7:0] m;
        logic ci;
        logic [8:0] s;
        logic [4:0] h;
        logic [8:0] dw;
        r = '0;
        x = f;
        y = a;
        ci = 1'b0;
        m = 8'h01 << b;
        case (op)
            OP_ADDC: ci = st[FLG_C];
            OP_SUB, OP_NEG, OP_SUBL: begin y = ~a; ci = 1'b1; end
            OP_SUBB: begin y = ~a; ci = st[FLG_C]; end
            OP_DEC, OP_DECSZ, OP_DECSNZ: y = 8'hFF;
            OP_INC, OP_INCSZ, OP_INCSNZ: begin y = 8'h00; ci = 1'b1; end
            default: ;
        endcase
        if (op == OP_NEG) x = 8'h00;
        if (op == OP_ADDL || op == OP_SUBL) x = k;
        s = {1'b0, x} + {1'b0, y} + {8'h00, ci};
        h = {1'b0, x[NIB_MSB:0]} + {1'b0, y[NIB_MSB:0]} + {4'h0, ci};
        dw = {1'b0, a} + ((a[NIB_MSB:0] > 4'h9 || st[FLG_DC]) ? 9'h006 : 9'h000);
        dw = dw + ((dw[FA_MSB:NIB_MSB+1] > 4'h9 || st[FLG_C] || dw[8]) ? 9'h060 : 9'h000);
        r.res = s[7:0];
        r.flg[FLG_C] = s[8];
        r.flg[FLG_DC] = h[4];
        r.flg[FLG_OV] = (x[7] == y[7]) && (s[7] != x[7]);
        r.wr_file = d;
        r.wr_acc = !d;
        case (op)
            OP_ADD, OP_ADDC, OP_SUB, OP_SUBB, OP_DEC, OP_INC:
                r.fmask = FM_ARITH;
            OP_ADDL, OP_SUBL:
            begin
                r.fmask = FM_ARITH;
                r.wr_file = 1'b0;
                r.wr_acc = 1'b1;
            end
            OP_AND: begin r.res = a & f; r.fmask = FM_Z; end
            OP_OR: begin r.res = a | f; r.fmask = FM_Z; end
            OP_XOR: begin r.res = a ^ f; r.fmask = FM_Z; end
            OP_COM: begin r.res = ~f; r.fmask = FM_Z; end
            OP_ANDL, OP_ORL, OP_XORL, OP_MOVL, OP_RETL:
            begin
                r.res = (op == OP_ANDL) ? (a & k) : (op == OP_ORL) ? (a | k) :
                    (op == OP_XORL) ? (a ^ k) : k;
                r.fmask = (op == OP_MOVL || op == OP_RETL) ? 4'h0 : FM_Z;
                r.wr_file = 1'b0;
                r.wr_acc = 1'b1;
            end
            OP_CLR, OP_SET, OP_NEG, OP_DAW:
            begin
                r.res = (op == OP_CLR) ? 8'h00 : (op == OP_SET) ? 8'hFF :
                    (op == OP_DAW) ? dw[7:0] : s[7:0];
                r.fmask = (op == OP_NEG) ? FM_ARITH : (op == OP_DAW) ? FM_C : 4'h0;
                r.flg[FLG_C] = (op == OP_DAW) ? dw[8] : s[8];
                r.wr_file = 1'b1;
                r.wr_acc = !d;
            end
            OP_DECSZ, OP_INCSZ: r.skip = (s[7:0] == 8'h00);
            OP_DECSNZ, OP_INCSNZ: r.skip = (s[7:0] != 8'h00);
            OP_RLC, OP_RRC:
            begin
                r.res = (op == OP_RLC) ? {f[6:0], st[FLG_C]} : {st[FLG_C], f[7:1]};
                r.flg[FLG_C] = (op == OP_RLC) ? f[7] : f[0];
                r.fmask = FM_C;
            end
            OP_RLN: r.res = {f[6:0], f[7]};
            OP_RRN: r.res = {f[0], f[7:1]};
            OP_SWAP: r.res = {f[NIB_MSB:0], f[FA_MSB:NIB_MSB+1]};
            OP_BCF, OP_BSF, OP_BTG:
            begin
                r.res = (op == OP_BCF) ? (f & ~m) : (op == OP_BSF) ? (f | m) : (f ^ m);
                r.wr_file = 1'b1;
                r.wr_acc = 1'b0;
            end
            OP_MOVWF, OP_TBLRD:
            begin
                r.res = (op == OP_MOVWF) ? a : f;
                r.wr_file = 1'b1;
                r.wr_acc = 1'b0;
            end
            default:
            begin
                r.wr_file = 1'b0;
                r.wr_acc = 1'b0;
                r.skip = (op == OP_CPEQ) ? (f == a) : (op == OP_CPGT) ? (f > a) :
                    (op == OP_CPLT) ? (f < a) : (op == OP_TST) ? (f == 8'h00) :
                    (op == OP_BTSC) ? ((f & m) == 8'h00) :
                    (op == OP_BTSS) ? ((f & m) != 8'h00) : 1'b0;
            end
        endcase
        r.flg[FLG_Z] = (r.res == 8'h00);
        return r;
    endfunction

    phase_t ph_q;
    logic [15:0] ir_q, fetch_q, pc_q, pc_d;
    logic [7:0] acc_q, opnd_q, bsr_q, pc_high_holding_latch_q;
    logic [3:0] st_q;
    logic [15:0] prod_q;
    alu_out_t alu_q;
    logic hold_q, disc_q, tw_busy_q, global_irq_disable_flag_q, run_q, mul_off_q;
    logic [15:0] stack_q [STACK_DEPTH];
    logic [SPW-1:0] sp_q;
    logic rd_ack_q;
    logic [31:0] rdata_q;

    // Decode and sequencing terms
    op_t op;
    logic q1, q2, q3, q4, force_nop, fetch_en, push, pop, to_pcl, tw_set;
    logic [7:0] k, tbl_byte;
    logic [15:0] stack_top;
    assign op = decode(ir_q, MUL_PRESENT && !mul_off_q);
    assign k = ir_q[FA_MSB:0];
    assign q1 = run_q && ph_q == PH_Q1;
    assign q2 = run_q && ph_q == PH_Q2;
    assign q3 = run_q && ph_q == PH_Q3;
    assign q4 = run_q && ph_q == PH_Q4;
    assign force_nop = hold_q || disc_q || tw_busy_q;
    assign fetch_en = !hold_q && !tw_busy_q;
    assign push = op == OP_CALL || op == OP_LONG_SUBROUTINE_CALL;
    assign pop = op == OP_RET || op == OP_RETURN_ENABLE_IRQ || op == OP_RETL;
    assign to_pcl = op == OP_TBLRD && k == PCL_FILE_ADDR;
    assign tw_set = q4 && op == OP_TBLWT && tbl_internal_in;
    assign tbl_byte = ir_q[T_POS] ? tbl_latch_in[15:8] : tbl_latch_in[7:0];
    assign stack_top = stack_q[sp_q - 1'b1];

    // Next program counter
    assign pc_d = (op == OP_GOTO || op == OP_CALL) ?
            {pc_q[15:TGT_W], ir_q[TGT_MSB:0]} :
        (op == OP_LONG_SUBROUTINE_CALL) ? {pc_high_holding_latch_q, k} :
        pop ? stack_top :
        to_pcl ? {pc_high_holding_latch_q, alu_q.res} :
        fetch_en ? pc_q + 16'h0001 : pc_q;

    // Quarter phase counter
    always_ff @(posedge sys_clk_in)
    begin
        if (reset_in) ph_q <= PH_Q1;
        else if (run_q) ph_q <= phase_t'(ph_q + 2'h1);
    end

    // Q1 load, Q2 operand read, Q3 execute
    always_ff @(posedge sys_clk_in)
    begin
        if (reset_in)
        begin
            ir_q <= W_NOP;
            opnd_q <= 8'h00;
            alu_q <= '0;
            prod_q <= 16'h0000;
        end
        else
        begin
            if (q1) ir_q <= force_nop ? W_NOP : fetch_q;
            if (q2) opnd_q <= (op == OP_TBLRD) ? tbl_byte : file_rdata_in;
            if (q3) alu_q <= alu(op, acc_q, opnd_q, k, ir_q[B_MSB:B_LSB],
                ir_q[D_POS], st_q);
            if (q3 && (op == OP_MULF || op == OP_MULL))
                prod_q <= acc_q * ((op == OP_MULL) ? k : opnd_q);
        end
    end

    // Q4 write-back of accumulator, flags and bank
    always_ff @(posedge sys_clk_in)
    begin
        if (reset_in)
        begin
            acc_q <= 8'h00;
            st_q <= 4'h0;
            bsr_q <= 8'h00;
        end
        else if (q4)
        begin
            if (alu_q.wr_acc) acc_q <= alu_q.res;
            st_q <= (st_q & ~alu_q.fmask) | (alu_q.flg & alu_q.fmask);
            if (op == OP_BANKLO) bsr_q[NIB_MSB:0] <= k[NIB_MSB:0];
            if (op == OP_BANKHI) bsr_q[FA_MSB:NIB_MSB+1] <= k[FA_MSB:NIB_MSB+1];
        end
    end

    // Q4 fetch, branch and extra-cycle bookkeeping
    always_ff @(posedge sys_clk_in)
    begin
        if (reset_in)
        begin
            pc_q <= PC_RESET;
            fetch_q <= W_NOP;
            hold_q <= 1'b0;
            disc_q <= 1'b0;
            sp_q <= '0;
        end
        else if (q4)
        begin
            pc_q <= pc_d;
            if (fetch_en) fetch_q <= pm_data_in;
            if (push) stack_q[sp_q] <= pc_q;
            if (push) sp_q <= sp_q + 1'b1;
            else if (pop) sp_q <= sp_q - 1'b1;
            hold_q <= to_pcl || (op == OP_TBLRD) ||
                (op == OP_TBLWT && !tbl_internal_in);
            disc_q <= alu_q.skip || push || pop || op == OP_GOTO || to_pcl
                || (hold_q && disc_q);
        end
    end

    // Internal programming stall; a new start beats a same-cycle interrupt
    always_ff @(posedge sys_clk_in)
    begin
        if (reset_in) tw_busy_q <= 1'b0;
        else if (tw_set) tw_busy_q <= 1'b1;
        else if (irq_event_in) tw_busy_q <= 1'b0;
    end

    // Bus decode
    logic wr_ctrl, wr_bank;
    logic [31:0] rd_mux;
    assign wr_ctrl = avs_write_in && avs_address_in == REG_CTRL && avs_byteenable_in[0];
    assign wr_bank = avs_write_in && avs_address_in == REG_BANK && avs_byteenable_in[1];
    assign rd_mux = (avs_address_in == REG_CTRL) ?
            {29'h0, global_irq_disable_flag_q, mul_off_q, run_q} :
        (avs_address_in == REG_CORE) ? {18'h0, ph_q, st_q, acc_q} :
        (avs_address_in == REG_BANK) ? {16'h0, pc_high_holding_latch_q, bsr_q} :
        (avs_address_in == REG_PC) ? {prod_q, pc_q} : 32'h0;

    // Control register and interrupt disable flag
    always_ff @(posedge sys_clk_in)
    begin
        if (reset_in)
        begin
            {global_irq_disable_flag_q, mul_off_q, run_q} <= CTRL_RESET;
            pc_high_holding_latch_q <= 8'h00;
        end
        else
        begin
            if (wr_ctrl) run_q <= avs_writedata_in[CTRL_RUN];
            if (wr_ctrl) mul_off_q <= avs_writedata_in[CTRL_MUL_OFF];
            if (q4 && op == OP_RETURN_ENABLE_IRQ) global_irq_disable_flag_q <= 1'b0;
            else if (wr_ctrl) global_irq_disable_flag_q <= avs_writedata_in[CTRL_IRQ_DIS];
            if (wr_bank) pc_high_holding_latch_q <= avs_writedata_in[15:8];
        end
    end

    // Reads answer after one wait cycle
    always_ff @(posedge sys_clk_in)
    begin
        if (reset_in)
        begin
            rd_ack_q <= 1'b0;
            rdata_q <= 32'h0;
        end
        else
        begin
            rd_ack_q <= avs_read_in && !rd_ack_q;
            if (avs_read_in && !rd_ack_q) rdata_q <= rd_mux;
        end
    end

    // Outputs
    assign avs_waitrequest_out = avs_read_in && !rd_ack_q;
    assign avs_readdata_out = rdata_q;
    assign pm_addr_out = pc_q;
    assign file_addr_out = k;
    assign file_wdata_out = alu_q.res;
    assign file_we_out = q4 && alu_q.wr_file;
    assign tbl_wdata_out = opnd_q;
    assign tbl_we_out = q4 && op == OP_TBLWT;
    assign tbl_hi_out = ir_q[T_POS];
    assign tbl_inc_out = q4 && (op == OP_TBLRD || op == OP_TBLWT) && ir_q[D_POS];
    assign phase_out = ph_q;
    assign irq_disable_out = global_irq_disable_flag_q;
endmodule // core_decoder

// ---- verif/core_decoder_props.sv ----
`timescale 1ns/1ps
module core_decoder_props (
    // Clock and reset
    input wire logic sys_clk_in,
    input wire logic reset_in,
    // Watched outputs
    input wire logic [15:0] pm_addr_out,
    input wire logic [7:0] file_addr_out,
    input wire logic file_we_out,
    input wire logic tbl_we_out,
    input wire logic tbl_inc_out,
    input wire core_pkg::phase_t phase_out
);
    import core_pkg::*;
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (reset_in);
    // Quarter phases after the first
    sequence s_q234;
        phase_out == PH_Q2 ##1 phase_out == PH_Q3 ##1 phase_out == PH_Q4;
    endsequence
    // Phase order and write slots
    property p_q_order;
        phase_out == PH_Q1 |=> s_q234;
    endproperty
    property p_q_wrap;
        phase_out == PH_Q4 |=> phase_out == PH_Q1;
    endproperty
    property p_we_q4;
        file_we_out |-> phase_out == PH_Q4;
    endproperty
    property p_we_one;
        file_we_out |=> (!file_we_out) [*3];
    endproperty
    property p_twe_q4;
        tbl_we_out |-> phase_out == PH_Q4;
    endproperty
    property p_inc_q4;
        tbl_inc_out |-> phase_out == PH_Q4;
    endproperty
    property p_pc_q1;
        $changed(pm_addr_out) |-> phase_out == PH_Q1;
    endproperty
    // Word loads at the Q1 edge, so the address first stands in Q2
    property p_fa_hold;
        phase_out == PH_Q2 |=> ($stable(file_addr_out)) [*3];
    endproperty
    a_q_order: assert property (p_q_order) else $error("phase order broken");
    a_q_wrap: assert property (p_q_wrap) else $error("phase wrap broken");
    a_we_q4: assert property (p_we_q4) else $error("file write off Q4");
    a_we_one: assert property (p_we_one) else $error("second file write");
    a_twe_q4: assert property (p_twe_q4) else $error("table write off Q4");
    a_inc_q4: assert property (p_inc_q4) else $error("pointer step off Q4");
    a_pc_q1: assert property (p_pc_q1) else $error("pc moved mid cycle");
    a_fa_hold: assert property (p_fa_hold) else $error("file address moved");
endmodule // core_decoder_props

bind core_decoder core_decoder_props core_decoder_props_i (.sys_clk_in, .reset_in,
    .pm_addr_out, .file_addr_out, .file_we_out, .tbl_we_out, .tbl_inc_out, .phase_out);

// ---- verif/pm_model.sv ----
`timescale 1ns/1ps
module pm_model (
    // Clock
    input wire logic sys_clk_in,
    // Program memory side
    input wire logic [15:0] pm_addr_in,
    output logic [15:0] pm_data_out,
    // File register side
    input wire logic [7:0] file_addr_in,
    input wire logic [7:0] file_wdata_in,
    input wire logic file_we_in,
    output logic [7:0] file_rdata_out
);
    logic [15:0] prog [256];
    logic [7:0] fmem [256];
    // Words and bytes at the addressed places
    assign pm_data_out = prog[pm_addr_in[7:0]];
    assign file_rdata_out = fmem[file_addr_in];
    // Whole byte written back at the strobe
    always @(posedge sys_clk_in)
    begin
        if (file_we_in)
            fmem[file_addr_in] <= file_wdata_in;
    end
endmodule // pm_model

// ---- verif/core_decoder_tb.sv ----
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin \
    $display("[FAIL] %s exp %h got %h", n, e, g); bad_count++; end end
module core_decoder_tb;
    import core_pkg::*;
    typedef struct packed {logic [7:0] k, f0; logic [15:0] op, w2; logic [7:0] acc, flg, fe;} row_t;
    logic sys_clk_in = 1'b0;
    logic reset_in = 1'b1;
    logic [15:0] pm_addr_out, pm_data_in;
    logic [7:0] file_addr_out, file_rdata_in, file_wdata_out;
    logic file_we_out, irq_disable_out, avs_waitrequest_out, hit;
    logic [3:0] avs_address_in = 4'h0;
    logic [3:0] avs_byteenable_in = 4'h0;
    logic avs_read_in = 1'b0;
    logic avs_write_in = 1'b0;
    logic [31:0] avs_writedata_in = 32'h0;
    logic [31:0] avs_readdata_out, rd_q;
    phase_t phase_out;
    int bad_count = 0;
    int n_tests = 0;
    // Literal, file byte, op, next word, then acc, flags, file byte
    row_t rows [19] = '{72'h17F80F10000017010F, 72'h01FF101000000007FF, 72'hF00F0A10000000040F,
        72'h5A5A0D1000005A0400, 72'h559928100000000000, 72'h55002B1000005500FF,
        72'h10103110B0EE100010, 72'h10803210B0EE100080, 72'h10803010B0EEEE0080,
        72'h33FF1F10B0EE330000, 72'h33022610B0EE010002, 72'h00811B100000000102,
        72'h008122100000030081, 72'h101034100000100010, 72'h00A53B1000000000AD,
        72'h00FF8F10000000007F, 72'h447F9F10B0EE44007F, 72'h7F00B1010000800A00,
        72'h5A00B45A0000000400};
    always #12.5 sys_clk_in = ~sys_clk_in;
    // Design and far side
    core_decoder core_decoder_i (.sys_clk_in, .reset_in, .pm_addr_out, .pm_data_in,
        .file_addr_out, .file_rdata_in, .file_wdata_out, .file_we_out,
        .tbl_latch_in(16'hA5C3), .tbl_internal_in(1'b0), .irq_event_in(1'b0),
        .tbl_wdata_out(), .tbl_we_out(), .tbl_hi_out(), .tbl_inc_out(), .phase_out,
        .irq_disable_out, .avs_address_in, .avs_read_in, .avs_write_in, .avs_writedata_in,
        .avs_byteenable_in, .avs_readdata_out, .avs_waitrequest_out);
    pm_model pm_model_i (.sys_clk_in, .pm_addr_in(pm_addr_out), .pm_data_out(pm_data_in),
        .file_addr_in(file_addr_out), .file_wdata_in(file_wdata_out),
        .file_we_in(file_we_out), .file_rdata_out(file_rdata_in));
    task automatic report_and_stop();
        if (bad_count == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // One bus transfer, held until waitrequest is seen low
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
        input logic [3:0] be);
        int n;
        n = 0;
        avs_address_in <= a;
        avs_writedata_in <= d;
        avs_byteenable_in <= be;
        avs_read_in <= !wr;
        avs_write_in <= wr;
        do
        begin
            @(posedge sys_clk_in);
            n++;
        end while (avs_waitrequest_out !== 1'b0 && n < 20);
        rd_q = avs_readdata_out;
        avs_read_in <= 1'b0;
        avs_write_in <= 1'b0;
        @(posedge sys_clk_in);
        if (n >= 20)
        begin
            bad_count++;
            report_and_stop();
        end
    endtask
    // Reset, load a program of listed opcodes only, release
    task automatic start(input logic [15:0] w0, w1, w2, input logic [7:0] f0);
        reset_in <= 1'b1;
        @(posedge sys_clk_in);
        for (int i = 0; i < 256; i++)
            pm_model_i.prog[i] = 16'h0000;
        pm_model_i.prog[0] = w0;
        pm_model_i.prog[1] = w1;
        pm_model_i.prog[2] = w2;
        pm_model_i.fmem[8'h10] = f0;
        reset_in <= 1'b0;
    endtask
    initial
    begin
        repeat (12) @(posedge sys_clk_in);
        foreach (rows[i])
        begin
            start({8'hB0, rows[i].k}, rows[i].op, rows[i].w2, rows[i].f0);
            repeat (32) @(posedge sys_clk_in);
            bus(1'b0, REG_CORE, 32'h0, 4'hF);
            `CHK("acc", rows[i].acc, rd_q[7:0])
            `CHK("flags", rows[i].flg, {4'h0, rd_q[11:8]})
            `CHK("file", rows[i].fe, pm_model_i.fmem[8'h10])
        end
        // Bank loads, long call, interrupt return
        start(16'hB805, 16'hBAA0, 16'hB803, 8'h00);
        pm_model_i.prog[4] = 16'hB734;
        pm_model_i.prog[5] = 16'hB066;
        pm_model_i.prog[8'h34] = W_RETURN_ENABLE_IRQ;
        pm_model_i.prog[8'h35] = 16'hB0EE;
        bus(1'b1, REG_CTRL, 32'h5, 4'h1);
        bus(1'b1, REG_BANK, 32'h1200, 4'h2);
        `CHK("irq_dis", 1'b1, irq_disable_out)
        hit = 1'b0;
        repeat (80)
        begin
            @(posedge sys_clk_in);
            if (pm_addr_out === 16'h1234)
                hit = 1'b1;
        end
        `CHK("long_subroutine_call", 1'b1, hit)
        `CHK("irq_dis", 1'b0, irq_disable_out)
        bus(1'b0, REG_CORE, 32'h0, 4'hF);
        `CHK("ret_acc", 8'h66, rd_q[7:0])
        bus(1'b0, REG_BANK, 32'h0, 4'hF);
        `CHK("bank", 32'h000012A3, rd_q)
        bus(1'b0, 4'h1, 32'h0, 4'hF);
        `CHK("unmapped", 32'h0, rd_q)
        report_and_stop();
    end
endmodule // core_decoder_tb
